// ---- rtl/cdv_top.sv ----
// Character mode display generator with vertical fine scrolling and an APB register slave.
// Summary of operation
// - Wide modes: glyph page from seven upper bits.
// - Narrow-glyph modes: six upper page bits only.
// - Eight bytes per glyph; page is high byte.
// - Low six or seven name bits index glyph.
// - Names rotate in a ring each line.
// - Modes two to seven; 40 or 20 characters.
// - Modes six, seven: name picks playfield colour.
// - Mode six eight lines; seven doubles each row.
// - Modes four, five: pixel 10 follows name bit.
// - Modes two, three: one colour, two luminances.
// - Mode three rows are ten lines high.
// - Mode three lowered glyphs: blank top, rows down.
// - Control bit two flips every glyph vertically.
// - Control bit one swaps luminances for marked names.
// - Control bit zero blanks marked names in modes two, three.
// - Inverse plus blank gives a solid cell.
// - Four-bit line counter sets block height.
// - Unchanged scroll bit keeps normal block height.
// - Scroll bit falling ends block at offset.
// - Zone's first block starts at the offset.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
module cdv_top
  import cdv_pkg::*;
#(
  parameter int CHARS_FULL = 40,  // Characters per line in the narrow-glyph modes.
  parameter int CHARS_HALF = 20   // Characters per line in the wide-glyph modes.
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // APB slave port.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // Display instruction and line timing from the list sequencer.
  input  wire logic        instr_valid,
  input  wire logic [7:0]  instr_op,
  input  wire logic        line_start,
  // Character names from the memory scan counter.
  input  wire logic        name_valid,
  input  wire logic [7:0]  name_data,
  output logic             name_ready,
  // Glyph data fetch from system memory.
  output logic             glyph_req,
  output logic      [15:0] glyph_addr,
  input  wire logic        glyph_valid,
  input  wire logic [7:0]  glyph_data,
  // Pixel codes to the colour and priority stage.
  output logic             pix_valid,
  output logic      [23:0] pix_codes,
  output logic             block_done
);

  // Refuse line widths the counters and the ring cannot serve.
  initial begin
    if (CHARS_FULL < 1 || CHARS_FULL > 63 || CHARS_HALF < 1 || CHARS_HALF > CHARS_FULL) begin
      $error("cdv_top character counts out of range");
    end
  end

  localparam logic [5:0] FULL_LEN = 6'(CHARS_FULL);  // Ring length for 40-column modes.
  localparam logic [5:0] HALF_LEN = 6'(CHARS_HALF);  // Ring length for 20-column modes.

  // Whole state of the block in one packed word.
  typedef struct packed {
    logic [7:0]    page;        // glyph_table_page.
    logic [2:0]    ctrl;        // glyph_render_control.
    logic [3:0]    vscroll;     // vertical_fine_offset.
    logic          pready;      // APB completion strobe.
    logic [31:0]   prdata;      // APB read data.
    logic          pslverr;     // APB error answer.
    logic [3:0]    mode;        // Mode of the current block.
    logic          prev_vs;     // Scroll enable of the previous block.
    logic [3:0]    line_ctr;    // block_line_counter.
    logic [3:0]    line_end;    // Last counter value of this block.
    logic          first_line;  // Names still need fetching.
    cdv_state_type st;          // Sequencer state.
    logic [5:0]    char_idx;    // Character position within the line.
    logic          name_ready;  // Ready for a name byte.
    logic          glyph_req;   // Glyph fetch strobe.
    logic [15:0]   glyph_addr;  // Glyph fetch address.
    logic [7:0]    cur_name;    // Name of the character being drawn.
    logic          pix_valid;   // Pixel group strobe.
    logic [23:0]   pix_codes;   // Eight three-bit pixel codes.
    logic          block_done;  // Last line of the block finished.
  } cdv_regs_type;

  cdv_regs_type r;       // Registered state.
  cdv_regs_type next_r;  // State at the next edge.

  logic [7:0] head_name;  // Name at the head of the ring.
  logic       ring_load;  // Shift a fetched name into the ring.
  logic       ring_rot;   // Rotate the ring by one character.
  logic [5:0] ring_len;   // Active ring length for the mode.

  // Ring length follows the column count of the block's mode.
  assign ring_len = cdv_is_wide(r.mode) ? HALF_LEN : FULL_LEN;

  // The names of a row live in a rotating ring, loaded once per block.
  cdv_name_ring #(
    .DEPTH     (CHARS_FULL)
  ) u_ring (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ring_len  (ring_len),
    .load_en   (ring_load),
    .load_name (name_data),
    .rotate_en (ring_rot),
    .head_name (head_name)
  );

  // Line within the cell after the optional vertical flip.
  function automatic logic [3:0] eff_line(input logic [3:0] mode, input logic [3:0] ctr,
                                          input logic flip);
    eff_line = flip ? 4'(cdv_std_end(mode) - ctr) : ctr;
  endfunction

  // Blank-line flag and glyph row for a line; mode 3 keeps rows at 0..7, a lowered
  // glyph moves its top two rows below the rest and shows blank lines above.
  function automatic logic [3:0] row_of(input logic [3:0] mode, input logic [3:0] ln,
                                        input logic [7:0] name);
    logic [3:0] res;
    res = {1'b0, ln[2:0]};
    if (mode == MODE_WIDE_T || mode == MODE_FOUR_T) begin
      res = {1'b0, ln[3:1]};
    end else if (mode == MODE_DESC) begin
      if (name[6:5] == 2'b11) begin
        if (ln < LOWER_LINES) begin
          res = {1'b1, 3'h0};
        end else if (ln >= GLYPH_ROWS) begin
          res = {1'b0, 3'(ln - GLYPH_ROWS)};
        end
      end else if (ln >= GLYPH_ROWS) begin
        res = {1'b1, 3'h0};
      end
    end
    row_of = res;
  endfunction

  // Glyph address: page bits above the name index above the row.
  function automatic logic [15:0] addr_of(input logic [3:0] mode, input logic [7:0] page,
                                          input logic [7:0] name, input logic [2:0] row);
    if (cdv_is_wide(mode)) begin
      addr_of = {page[7:1], name[5:0], row};
    end else begin
      addr_of = {page[7:2], name[6:0], row};
    end
  endfunction

  // Pixel codes for one glyph byte in the current mode.
  function automatic logic [23:0] pix_of(input logic [3:0] mode, input logic [2:0] ctrl,
                                         input logic [7:0] name, input logic [7:0] data);
    logic [7:0]  d;
    logic [1:0]  p;
    logic [23:0] res;
    d   = data;
    res = '0;
    if (cdv_is_lum(mode)) begin
      // Blank first, then invert, so both together give a solid cell.
      if (ctrl[CTL_BLANK_BIT] && name[NAME_ATTR_BIT]) begin
        d = 8'h00;
      end
      if (ctrl[CTL_INV_BIT] && name[NAME_ATTR_BIT]) begin
        d = ~d;
      end
      for (int i = 0; i < 8; i++) begin
        res[3*i +: 3] = d[i] ? PIX_PF1 : PIX_PF2;
      end
    end else if (mode == MODE_FOUR_S || mode == MODE_FOUR_T) begin
      // Each two-bit pixel is twice as wide, so it fills two slots.
      for (int i = 0; i < 8; i++) begin
        p = d[2*(i/2) +: 2];
        case (p)
          2'b00:   res[3*i +: 3] = PIX_BAK;
          2'b01:   res[3*i +: 3] = PIX_PF0;
          2'b10:   res[3*i +: 3] = name[NAME_ATTR_BIT] ? PIX_PF2 : PIX_PF1;
          default: res[3*i +: 3] = name[NAME_ATTR_BIT] ? PIX_PF3 : PIX_PF2;
        endcase
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        res[3*i +: 3] = d[i] ? 3'(PIX_PF0 + {1'b0, name[7:6]}) : PIX_BAK;
      end
    end
    pix_of = res;
  endfunction

  logic       apb_done;   // Access phase completes at this edge.
  logic [3:0] ln_eff;     // Cell line after flipping.
  logic [3:0] row_info;   // Blank flag and glyph row for the head name.
  logic       new_vs;     // Scroll enable of an arriving instruction.
  logic       mode_ok;    // Arriving instruction is a character mode.

  // Next-state logic for the APB slave and the character engine.
  always_comb begin
    next_r            = r;
    next_r.pix_valid  = 1'b0;
    next_r.glyph_req  = 1'b0;
    next_r.block_done = 1'b0;
    next_r.pready     = 1'b0;
    next_r.pslverr    = 1'b0;
    ring_load         = 1'b0;
    ring_rot          = 1'b0;
    apb_done          = psel && penable && r.pready;
    ln_eff            = eff_line(r.mode, r.line_ctr, r.ctrl[CTL_FLIP_BIT]);
    row_info          = row_of(r.mode, ln_eff, head_name);
    new_vs            = instr_op[OP_VSCROLL_BIT];
    mode_ok           = (instr_op[3:0] >= MODE_TEXT) && (instr_op[3:0] <= MODE_WIDE_T);

    // One wait state: pready rises in the second access cycle, registered.
    if (psel && penable && !r.pready) begin
      next_r.pready = 1'b1;
      next_r.prdata = '0;
      case (paddr)
        REG_PAGE_OFS: next_r.prdata = {24'h000000, r.page};
        REG_CTRL_OFS: next_r.prdata = {29'h00000000, r.ctrl};
        REG_VSCR_OFS: next_r.prdata = {28'h0000000, r.vscroll};
        REG_STAT_OFS: next_r.prdata = {20'h00000, r.mode, r.line_ctr, 3'h0, r.st != ST_IDLE};
        default:      next_r.pslverr = 1'b1;
      endcase
    end
    // Writes land only at the completing edge; the status word ignores them.
    if (apb_done && pwrite) begin
      case (paddr)
        REG_PAGE_OFS: next_r.page = pwdata[7:0];
        REG_CTRL_OFS: next_r.ctrl = pwdata[2:0];
        REG_VSCR_OFS: next_r.vscroll = pwdata[3:0];
        default:      next_r.page = r.page;
      endcase
    end

    // Character engine sequencer.
    case (r.st)
      ST_IDLE: begin
        // A new character block sets its counter limits from the scroll bit history.
        if (instr_valid && mode_ok) begin
          next_r.mode       = instr_op[3:0];
          next_r.prev_vs    = new_vs;
          next_r.first_line = 1'b1;
          next_r.st         = ST_WAIT_LINE;
          next_r.line_ctr   = 4'h0;
          next_r.line_end   = cdv_std_end(instr_op[3:0]);
          if (r.prev_vs && !new_vs) begin
            next_r.line_end = r.vscroll;
          end else if (!r.prev_vs && new_vs) begin
            // Top block of a zone loses its first lines; clamp keeps one line.
            if (r.vscroll > cdv_std_end(instr_op[3:0])) begin
              next_r.line_ctr = cdv_std_end(instr_op[3:0]);
            end else begin
              next_r.line_ctr = r.vscroll;
            end
          end
        end else if (instr_valid) begin
          // Other instruction types pass their own scroll bit into the history, so bit 5 clear breaks a scrolled zone.
          next_r.prev_vs = new_vs;
        end
      end
      ST_WAIT_LINE: begin
        // Names are fetched on the first line only; later lines reuse the ring.
        if (line_start) begin
          next_r.char_idx = 6'h00;
          if (r.first_line) begin
            next_r.st         = ST_LOAD;
            next_r.name_ready = 1'b1;
          end else begin
            next_r.st = ST_ISSUE;
          end
        end
      end
      ST_LOAD: begin
        if (name_valid) begin
          ring_load       = 1'b1;
          next_r.char_idx = 6'(r.char_idx + 6'h01);
          if (r.char_idx == 6'(ring_len - 6'h01)) begin
            next_r.name_ready = 1'b0;
            next_r.char_idx   = 6'h00;
            next_r.st         = ST_ISSUE;
          end
        end
      end
      ST_ISSUE: begin
        next_r.cur_name = head_name;
        if (row_info[3]) begin
          // Blank line of a mode 3 cell: no fetch, emit an all-zero byte.
          next_r.pix_valid = 1'b1;
          next_r.pix_codes = pix_of(r.mode, r.ctrl, head_name, 8'h00);
          ring_rot         = 1'b1;
        end else begin
          next_r.glyph_req  = 1'b1;
          next_r.glyph_addr = addr_of(r.mode, r.page, head_name, row_info[2:0]);
          next_r.st         = ST_WAIT_DATA;
        end
      end
      ST_WAIT_DATA: begin
        if (glyph_valid) begin
          next_r.pix_valid = 1'b1;
          next_r.pix_codes = pix_of(r.mode, r.ctrl, r.cur_name, glyph_data);
          ring_rot         = 1'b1;
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase

    // After each character, step along the line; the counter moves after a full line.
    if (ring_rot) begin
      next_r.st       = ST_ISSUE;
      next_r.char_idx = 6'(r.char_idx + 6'h01);
      if (r.char_idx == 6'(ring_len - 6'h01)) begin
        next_r.char_idx   = 6'h00;
        next_r.first_line = 1'b0;
        if (r.line_ctr == r.line_end) begin
          next_r.block_done = 1'b1;
          next_r.st         = ST_IDLE;
        end else begin
          next_r.line_ctr = 4'(r.line_ctr + 4'h1);
          next_r.st       = ST_WAIT_LINE;
        end
      end
    end
  end

  // Register the whole state; no control bit is left undefined after reset.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r         <= '0;
      r.page    <= PAGE_RESET;
      r.ctrl    <= CTRL_RESET;
      r.vscroll <= VSCR_RESET;
      r.st      <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // Every output comes straight from the state register.
  assign pready     = r.pready;
  assign prdata     = r.prdata;
  assign pslverr    = r.pslverr;
  assign name_ready = r.name_ready;
  assign glyph_req  = r.glyph_req;
  assign glyph_addr = r.glyph_addr;
  assign pix_valid  = r.pix_valid;
  assign pix_codes  = r.pix_codes;
  assign block_done = r.block_done;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_page_wide;
    glyph_req && cdv_is_wide(r.mode) |-> glyph_addr[15:9] == $past(r.page[7:1]);
  endproperty
  a_page_wide: assert property (p_page_wide) else $error("wide glyph page wrong");

  property p_page_full;
    glyph_req && !cdv_is_wide(r.mode) |-> glyph_addr[15:10] == $past(r.page[7:2]);
  endproperty
  a_page_full: assert property (p_page_full) else $error("full glyph page wrong");

  property p_name_index;
    glyph_req && !cdv_is_wide(r.mode) |-> glyph_addr[9:3] == r.cur_name[6:0];
  endproperty
  a_name_index: assert property (p_name_index) else $error("name index wrong");

  property p_row_plain;
    glyph_req && r.mode == MODE_TEXT && !r.ctrl[CTL_FLIP_BIT]
      |-> glyph_addr[2:0] == r.line_ctr[2:0];
  endproperty
  a_row_plain: assert property (p_row_plain) else $error("glyph row wrong");

  property p_row_double;
    glyph_req && r.mode == MODE_WIDE_T && !r.ctrl[CTL_FLIP_BIT]
      |-> glyph_addr[2:0] == r.line_ctr[3:1];
  endproperty
  a_row_double: assert property (p_row_double) else $error("row doubling wrong");

  property p_lowered_top;
    glyph_req && r.mode == MODE_DESC && !r.ctrl[CTL_FLIP_BIT] && r.cur_name[6:5] == 2'b11
      |-> r.line_ctr >= LOWER_LINES;
  endproperty
  a_lowered_top: assert property (p_lowered_top) else $error("lowered glyph fetched");

  property p_blank_char;
    pix_valid && cdv_is_lum(r.mode) && r.ctrl[CTL_BLANK_BIT] && !r.ctrl[CTL_INV_BIT]
      && r.cur_name[NAME_ATTR_BIT] |-> pix_codes == {8{PIX_PF2}};
  endproperty
  a_blank_char: assert property (p_blank_char) else $error("blank char shows data");

  property p_scroll_end;
    instr_valid && r.st == ST_IDLE && mode_ok && r.prev_vs && !new_vs
      |=> r.line_end == $past(r.vscroll) && r.line_ctr == 4'h0;
  endproperty
  a_scroll_end: assert property (p_scroll_end) else $error("bottom block end wrong");

  property p_steady_block;
    instr_valid && r.st == ST_IDLE && mode_ok && r.prev_vs == new_vs
      |=> r.line_ctr == 4'h0 && r.line_end == cdv_std_end(r.mode);
  endproperty
  a_steady_block: assert property (p_steady_block) else $error("steady block height wrong");

  c_block_done: cover property (block_done);
  c_desc_pixels: cover property (pix_valid && r.mode == MODE_DESC);
  c_wide_fetch: cover property (glyph_req && r.mode == MODE_WIDE_T);

endmodule

// ---- rtl/cdv_pkg.sv ----
// Shared constants, types and helper functions for the character display generator.
package cdv_pkg;

  // APB register byte offsets, one aligned 32-bit word each.
  localparam logic [11:0] REG_PAGE_OFS   = 12'h000;
  localparam logic [11:0] REG_CTRL_OFS   = 12'h004;
  localparam logic [11:0] REG_VSCR_OFS   = 12'h008;
  localparam logic [11:0] REG_STAT_OFS   = 12'h00C;

  // Reset values of the software registers.
  localparam logic [7:0]  PAGE_RESET     = 8'h00;
  localparam logic [2:0]  CTRL_RESET     = 3'h0;
  localparam logic [3:0]  VSCR_RESET     = 4'h0;

  // Bit positions in the render control word, the opcode and the name byte.
  localparam int          CTL_BLANK_BIT  = 0;
  localparam int          CTL_INV_BIT    = 1;
  localparam int          CTL_FLIP_BIT   = 2;
  localparam int          OP_VSCROLL_BIT = 5;
  localparam int          NAME_ATTR_BIT  = 7;

  // Character mode codes held in the low opcode nibble.
  localparam logic [3:0]  MODE_TEXT      = 4'h2;
  localparam logic [3:0]  MODE_DESC      = 4'h3;
  localparam logic [3:0]  MODE_FOUR_S    = 4'h4;
  localparam logic [3:0]  MODE_FOUR_T    = 4'h5;
  localparam logic [3:0]  MODE_WIDE_S    = 4'h6;
  localparam logic [3:0]  MODE_WIDE_T    = 4'h7;

  // Last line counter value of a standard block per height class.
  localparam logic [3:0]  END_EIGHT      = 4'h7;
  localparam logic [3:0]  END_TEN        = 4'h9;
  localparam logic [3:0]  END_SIXTEEN    = 4'hF;

  // Number of blank lines that sit above a lowered glyph.
  localparam logic [3:0]  LOWER_LINES    = 4'h2;
  localparam logic [3:0]  GLYPH_ROWS     = 4'h8;

  // Pixel codes handed to the colour stage.
  localparam logic [2:0]  PIX_BAK        = 3'h0;
  localparam logic [2:0]  PIX_PF0        = 3'h1;
  localparam logic [2:0]  PIX_PF1        = 3'h2;
  localparam logic [2:0]  PIX_PF2        = 3'h3;
  localparam logic [2:0]  PIX_PF3        = 3'h4;

  // Sequencer states of the character engine.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT_LINE,
    ST_LOAD,
    ST_ISSUE,
    ST_WAIT_DATA
  } cdv_state_type;

  // Standard end value of the line counter for a character mode.
  function automatic logic [3:0] cdv_std_end(input logic [3:0] mode);
    case (mode)
      MODE_DESC:   cdv_std_end = END_TEN;
      MODE_FOUR_T: cdv_std_end = END_SIXTEEN;
      MODE_WIDE_T: cdv_std_end = END_SIXTEEN;
      default:     cdv_std_end = END_EIGHT;
    endcase
  endfunction

  // True for the 20-character modes with a 64-glyph table.
  function automatic logic cdv_is_wide(input logic [3:0] mode);
    cdv_is_wide = (mode == MODE_WIDE_S) || (mode == MODE_WIDE_T);
  endfunction

  // True for the two-luminance text modes.
  function automatic logic cdv_is_lum(input logic [3:0] mode);
    cdv_is_lum = (mode == MODE_TEXT) || (mode == MODE_DESC);
  endfunction

endpackage

// ---- rtl/cdv_name_ring.sv ----
// Rotating shift register that holds the character names of one display row.
`timescale 1ns/100ps
module cdv_name_ring
  import cdv_pkg::*;
#(
  parameter int DEPTH = 40
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Active ring length and shift controls.
  input  wire logic [5:0]       ring_len,
  input  wire logic             load_en,
  input  wire logic [7:0]       load_name,
  input  wire logic             rotate_en,
  // Name at the head of the ring, straight from a register.
  output logic      [7:0]       head_name
);

  // Refuse depths the six-bit length cannot describe.
  initial begin
    if (DEPTH < 1 || DEPTH > 63) begin
      $error("cdv_name_ring depth out of range");
    end
  end

  // Whole state of the ring in one packed word.
  typedef struct packed {
    logic [DEPTH-1:0][7:0] slot;
  } cdv_ring_type;

  cdv_ring_type ring;       // Registered ring contents.
  cdv_ring_type next_ring;  // Value the ring takes at the next edge.

  // Each shift moves every slot one step to the head; the tail of the active length
  // takes the new name on a load, or the old head on a rotate, so a row wraps around.
  always_comb begin
    next_ring = ring;
    if (load_en || rotate_en) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (i == int'(ring_len) - 1) begin
          next_ring.slot[i] = load_en ? load_name : ring.slot[0];
        end else if (i < DEPTH - 1) begin
          next_ring.slot[i] = ring.slot[i+1];
        end
      end
    end
  end

  // Register the ring; reset clears every slot.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ring <= '0;
    end else begin
      ring <= next_ring;
    end
  end

  assign head_name = ring.slot[0];

endmodule

// ---- testbench/cdv_mem_model.sv ----
// System memory model that supplies character names and answers glyph fetches.
`timescale 1ns/100ps
module cdv_mem_model
  import cdv_pkg::*;
#(
  parameter logic [7:0] NAME = 8'hE3  // Name byte offered for every position.
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Name stream.
  input  wire logic        name_ready,
  output logic             name_valid,
  output logic      [7:0]  name_data,
  // Glyph fetch.
  input  wire logic        glyph_req,
  input  wire logic [15:0] glyph_addr,
  output logic             glyph_valid,
  output logic      [7:0]  glyph_data
);
  logic [1:0] wait_cnt;  // Cycles left before the answer.
  logic       busy;      // A fetch is outstanding.
  logic       slow;      // Alternates prompt and slow answers.
  logic [7:0] held;      // Low address byte doubles as the glyph data.
  // Names are always on offer; the engine takes one whenever it is ready.
  assign name_valid = 1'b1;
  assign name_data  = NAME;
  // Answer each fetch after one or three cycles; outside an answer the
  // data lines toggle so a late sample never sees a stale value.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      glyph_valid <= 1'b0;
      glyph_data  <= 8'h00;
      busy        <= 1'b0;
      slow        <= 1'b0;
      wait_cnt    <= 2'h0;
      held        <= 8'h00;
    end else begin
      glyph_valid <= 1'b0;
      glyph_data  <= ~glyph_data;
      if (glyph_req === 1'b1) begin
        busy     <= 1'b1;
        held     <= glyph_addr[7:0];
        wait_cnt <= slow ? 2'h2 : 2'h0;
        slow     <= ~slow;
      end else if (busy && wait_cnt == 2'h0) begin
        glyph_valid <= 1'b1;
        glyph_data  <= held;
        busy        <= 1'b0;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule

// ---- testbench/tb_cdv_top.sv ----
// Self-checking testbench for the character display generator.
`timescale 1ns/100ps
module tb_cdv_top;
  import cdv_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, instr_valid = 1'b0, line_start = 1'b0, name_valid, name_ready;
  logic [7:0] instr_op = 8'h00, name_data, glyph_data;
  logic glyph_req, glyph_valid, pix_valid, block_done;
  logic [15:0] glyph_addr, faddr;
  logic [23:0] pix_codes, fpix;
  int bad_count = 0, compares = 0, pcnt = 0, cyc = 0, ncnt = 0;
  logic [7:0] ops [9] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h22, 8'h22, 8'h02, 8'h06};
  int lines [9] = '{32, 40, 32, 64, 32, 20, 32, 16, 16};
  cdv_top #(.CHARS_FULL(4), .CHARS_HALF(2)) u_cdv_top (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .instr_valid(instr_valid),
    .instr_op(instr_op), .line_start(line_start), .name_valid(name_valid),
    .name_data(name_data), .name_ready(name_ready), .glyph_req(glyph_req),
    .glyph_addr(glyph_addr), .glyph_valid(glyph_valid), .glyph_data(glyph_data),
    .pix_valid(pix_valid), .pix_codes(pix_codes), .block_done(block_done));
  cdv_mem_model u_cdv_mem_model (.sys_clk(sys_clk), .rst(rst), .name_ready(name_ready),
    .name_valid(name_valid), .name_data(name_data), .glyph_req(glyph_req),
    .glyph_addr(glyph_addr), .glyph_valid(glyph_valid), .glyph_data(glyph_data));
  // Clock of 4 ns period.
  always #2 sys_clk = ~sys_clk;
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One comparison with case equality.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Issues one display instruction and checks the number of pixel groups of the block.
  task automatic run(input logic [7:0] op, input int n);
    pcnt = 0;
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    do @(posedge sys_clk); while (block_done !== 1'b1);
    repeat (2) @(posedge sys_clk);
    chk(32'(pcnt), 32'(n));
  endtask
  // Line pulses every 50 cycles, long enough for a whole line of work.
  always @(posedge sys_clk) begin
    cyc++;
    line_start <= (cyc % 50 == 0);
    if (cyc == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  // Records the first pixel group of each block, and the fetch address of a fetch that comes before it.
  always @(posedge sys_clk) begin
    if (glyph_req === 1'b1 && pcnt == 0) faddr = glyph_addr;
    if (name_ready === 1'b1) ncnt++;
    if (pix_valid === 1'b1) begin
      if (pcnt == 0) fpix = pix_codes;
      pcnt++;
    end
  end
  // Main sequence.
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, REG_PAGE_OFS, 32'h0);
    chk(rd, 32'(PAGE_RESET));
    apb(1'b1, REG_PAGE_OFS, 32'h0000_00A5);
    apb(1'b0, REG_PAGE_OFS, 32'h0);
    chk(rd, 32'h0000_00A5);
    apb(1'b1, REG_VSCR_OFS, 32'h0000_0003);
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, REG_CTRL_OFS, 32'h0);
    // Scroll bit set on the zone's first block and cleared on its last.
    for (int i = 0; i < 9; i++) begin
      run(ops[i], lines[i]);
      if (i == 0) chk(32'(faddr), 32'h0000_A718);
      if (i == 2) chk(32'(fpix), 32'h0000_96C0);
    end
    chk(32'(faddr), 32'h0000_A518);
    chk(32'(fpix), 32'h0000_4800);
    chk(32'(ncnt), 32'h0000_0020);
    apb(1'b1, REG_CTRL_OFS, 32'h0000_0001);
    run(8'h02, 32);
    chk(32'(fpix), 32'h006D_B6DB);
    apb(1'b1, REG_CTRL_OFS, 32'h0000_0002);
    run(8'h02, 32);
    chk(32'(fpix), 32'h0049_3692);
    apb(1'b1, REG_CTRL_OFS, 32'h0000_0003);
    run(8'h02, 32);
    chk(32'(fpix), 32'h0049_2492);
    apb(1'b1, REG_CTRL_OFS, 32'h0000_0004);
    run(8'h02, 32);
    chk(32'(faddr), 32'h0000_A71F);
    apb(1'b0, REG_STAT_OFS, 32'h0);
    chk(rd, 32'h0000_0270);
    finish_test();
  end
endmodule
